// ==== rtl/acc_pkg.sv ====
// shared constants and types of the converter conversion control block
`default_nettype none
package acc_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_RESULT_HIGH    = 8'h04;
	localparam logic [7:0] OFS_RESULT_LOW     = 8'h08;
	localparam logic [7:0] OFS_CLOCK          = 8'h0C;
	localparam logic [7:0] OFS_BREAK_CONTROL  = 8'h10;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int SC_DONE_BIT   = 7;
	localparam int SC_IRQ_EN_BIT = 6;
	localparam int SC_CONT_BIT   = 5;
	localparam int SC_CH_LSB     = 0;
	localparam int CK_ASYNC_BIT  = 0;
	localparam int CK_LSAMP_BIT  = 1;
	localparam int CK_MODE_LSB   = 2;
	localparam int CK_DIV_LSB    = 4;
	localparam int BC_BCE_BIT    = 0;

	// ----------------------------------------------------------------
	// reset values and codes
	// ----------------------------------------------------------------
	localparam logic [4:0] CH_OFF        = 5'h1F;
	localparam logic [4:0] CH_RESET      = 5'h1F;
	localparam logic [4:0] CH_PIN8       = 5'h18;
	localparam logic [4:0] CH_PIN9       = 5'h19;
	localparam logic [4:0] CH_BANDGAP    = 5'h1A;
	localparam logic [4:0] CH_REFH       = 5'h1D;
	localparam logic [4:0] CH_REFL       = 5'h1E;
	localparam logic [4:0] CH_PIN_LAST   = 5'h07;
	localparam logic [1:0] MODE_8BIT     = 2'h0;
	localparam logic [1:0] MODE_RESET    = 2'h0;
	localparam logic [1:0] DIV_RESET     = 2'h0;

	// ----------------------------------------------------------------
	// timing, in half cycles of the conversion clock
	// ----------------------------------------------------------------
	localparam logic [5:0] SAMPLE_SHORT_HALVES = 6'h07; // 3.5 cycles
	localparam logic [5:0] SAMPLE_LONG_HALVES  = 6'h2F; // 23.5 cycles

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		ACC_SRC_PIN,
		ACC_SRC_BANDGAP,
		ACC_SRC_REFH,
		ACC_SRC_REFL,
		ACC_SRC_UNUSED,
		ACC_SRC_OFF
	} acc_src_t;

	typedef struct packed
	{
		logic     power_on;
		logic     pad_isolate;
		logic     sample;
		logic     convert;
		acc_src_t src;
		logic [3:0] pin;
	} acc_ana_ctl_t;

endpackage : acc_pkg
`default_nettype wire

// ==== rtl/acc_clk_div.sv ====
// conversion clock divider producing half-period enable pulses
`default_nettype none
module acc_clk_div
(
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic       clear,
	input  wire logic [1:0] div_sel,
	output var  logic       half_tick_ff
);

	logic [2:0] cnt_ff;
	logic [2:0] limit;
	logic       at_limit;

	// ------------------------------------------------------------
	// divide by 1, 2, 4 or 8
	// ------------------------------------------------------------
	assign limit    = 3'((4'h1 << div_sel) - 4'h1);
	assign at_limit = (cnt_ff == limit);

	// clear realigns the phase so each sample window is exact
	always_ff @(posedge core_clk)
	begin
		if (!resetn || clear)
		begin
			cnt_ff       <= 3'h0;
			half_tick_ff <= 1'b0;
		end
		else
		begin
			cnt_ff       <= at_limit ? 3'h0 : 3'(cnt_ff + 3'h1);
			half_tick_ff <= at_limit;
		end
	end

endmodule : acc_clk_div
`default_nettype wire

// ==== rtl/acc_sar_seq.sv ====
// sample and convert sequencer of one conversion
`default_nettype none
module acc_sar_seq
(
	input  wire logic core_clk,
	input  wire logic resetn,
	input  wire logic start,
	input  wire logic abort,
	input  wire logic half_tick,
	input  wire logic long_sample,
	input  wire logic ana_done,
	output var  logic sampling_ff,
	output var  logic converting_ff,
	output var  logic done_ff
);

	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} acc_seq_t;

	acc_seq_t   state_ff;
	acc_seq_t   nxt_state;
	logic [5:0] cnt_ff;
	logic [5:0] nxt_cnt;
	logic [5:0] sample_limit;
	logic       nxt_done;

	assign sample_limit = long_sample ? acc_pkg::SAMPLE_LONG_HALVES : acc_pkg::SAMPLE_SHORT_HALVES; // RULE_20

	// ------------------------------------------------------------
	// next state; a start restarts, an abort ends without done
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_done  = 1'b0;
		if (start)
		begin
			nxt_state = ST_SAMPLE;
			nxt_cnt   = 6'h00;
		end
		else if (abort)
			nxt_state = ST_IDLE; // RULE_21
		else
		begin
			unique case (state_ff)
				ST_IDLE: ;
				ST_SAMPLE:
					if (half_tick)
					begin
						if (nxt_cnt == 6'(sample_limit - 6'h01))
							nxt_state = ST_CONVERT;
						nxt_cnt = 6'(cnt_ff + 6'h01);
					end
				ST_CONVERT:
					if (ana_done)
					begin
						nxt_state = ST_IDLE; // RULE_13
						nxt_done  = 1'b1;
					end
			endcase
		end
	end

	// state registers
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			state_ff      <= ST_IDLE;
			cnt_ff        <= 6'h00;
			done_ff       <= 1'b0;
			sampling_ff   <= 1'b0;
			converting_ff <= 1'b0;
		end
		else
		begin
			state_ff      <= nxt_state;
			cnt_ff        <= nxt_cnt;
			done_ff       <= nxt_done;
			sampling_ff   <= (nxt_state == ST_SAMPLE);
			converting_ff <= (nxt_state == ST_CONVERT);
		end
	end

endmodule : acc_sar_seq
`default_nettype wire

// ==== rtl/acc_conv_ctrl.sv ====
// converter conversion control: apb registers, modes, flag, decode
//
// Notes on behaviour
// RULE_01: break clear enabled lets clears stick
// RULE_02: clear disabled freezes status during break
// RULE_03: status write aborts, restarts unless off
// RULE_04: done flag set on end, cleared
// RULE_05: interrupt follows done flag when enabled
// RULE_06: continuous mode repeats and updates results
// RULE_07: continuous stops: reset, stop, clock write
// RULE_08: after stop abort, only write restarts
// RULE_09: continuous write restarts a fresh sequence
// RULE_10: single mode: one conversion per write
// RULE_11: software keeps bus clock fast enough
// RULE_12: all ones channel powers off, isolates
// RULE_13: idle low power after every conversion
// RULE_14: five bit channel decode to sources
// RULE_15: unused codes still convert, undefined result
// RULE_16: software keeps detector powered for bandgap
// RULE_17: no external trigger, writes start only
// RULE_18: done flag sets regardless of enable
// RULE_19: ten bit high read locks results
// RULE_20: long sample 23.5, short 3.5 cycles
// RULE_21: abort keeps old result, no flag
`default_nettype none
module acc_conv_ctrl
(
	input  wire logic                  core_clk,
	input  wire logic                  resetn,
	input  wire logic [7:0]            paddr,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [31:0]           pwdata,
	output var  logic [31:0]           prdata,
	output var  logic                  pready,
	output var  logic                  pslverr,
	input  wire logic                  break_state,
	input  wire logic                  stop_mode,
	input  wire logic [9:0]            ana_result,
	input  wire logic                  ana_done,
	output var  acc_pkg::acc_ana_ctl_t ana_ctl,
	output var  logic                  conv_irq
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic        pready_ff;
	logic [31:0] prdata_ff;
	logic        pslverr_ff;
	logic        done_flag_ff;
	logic        irq_en_ff;
	logic        cont_ff;
	logic [4:0]  ch_ff;
	logic        async_en_ff;
	logic        long_sample_ff;
	logic [1:0]  mode_ff;
	logic [1:0]  div_ff;
	logic        bce_ff;
	logic [9:0]  result_ff;
	logic [9:0]  conv_data_ff;
	logic        lock_ff;
	logic        cont_run_ff;
	logic        stop_q_ff;
	logic        irq_ff;
	acc_pkg::acc_ana_ctl_t ana_ctl_ff;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	wire         setup      = psel && !penable;
	wire         access     = psel && penable && pready_ff;
	wire         sel_sc     = (paddr == acc_pkg::OFS_STATUS_CONTROL);
	wire         sel_rh     = (paddr == acc_pkg::OFS_RESULT_HIGH);
	wire         sel_rl     = (paddr == acc_pkg::OFS_RESULT_LOW);
	wire         sel_ck     = (paddr == acc_pkg::OFS_CLOCK);
	wire         sel_bc     = (paddr == acc_pkg::OFS_BREAK_CONTROL);
	wire         mapped     = sel_sc || sel_rh || sel_rl || sel_ck || sel_bc;
	wire         wr_sc      = access && pwrite && sel_sc;
	wire         wr_ck      = access && pwrite && sel_ck;
	wire         wr_bc      = access && pwrite && sel_bc;
	wire         rd_rh      = access && !pwrite && sel_rh;
	wire         rd_rl      = access && !pwrite && sel_rl;
	wire [4:0]   wr_ch      = pwdata[acc_pkg::SC_CH_LSB +: 5];
	wire         wr_cont    = pwdata[acc_pkg::SC_CONT_BIT];
	wire         wr_ch_on   = (wr_ch != acc_pkg::CH_OFF);

	// ------------------------------------------------------------
	// status protection during break
	// ------------------------------------------------------------
	// with the clear enable low, bus traffic in break touches no status
	wire         status_may_change = !break_state || bce_ff; // RULE_01 RULE_02

	// ------------------------------------------------------------
	// conversion control
	// ------------------------------------------------------------
	wire         seq_done;
	wire         seq_sampling;
	wire         seq_converting;
	wire         half_tick;
	wire         ten_bit    = (mode_ff != acc_pkg::MODE_8BIT);
	wire         stop_entry = stop_mode && !stop_q_ff;
	wire         stop_abort = stop_entry && !async_en_ff; // RULE_07
	// status writes and continuous repeats are the only start sources; there is no trigger pin
	wire         start_write = wr_sc && wr_ch_on; // RULE_03 RULE_10 RULE_17
	wire         start_cont  = seq_done && cont_run_ff && !wr_ck && !stop_abort; // RULE_06
	wire         conv_start  = start_write || start_cont;
	wire         conv_abort  = wr_sc || stop_abort; // RULE_03
	wire         result_take = seq_done && !(ten_bit && lock_ff); // RULE_19

	// continuous run: a fresh sequence only from a status write
	wire nxt_cont_run = wr_sc ? (wr_cont && wr_ch_on) :  // RULE_09 RULE_12
	                    (wr_ck || stop_abort) ? 1'b0 :   // RULE_07 RULE_08
	                    cont_run_ff;

	// done flag: an end of conversion wins over any clear
	wire clear_ev       = (wr_sc || rd_rl) && status_may_change; // RULE_04
	wire nxt_done_flag  = seq_done ? 1'b1 :                      // RULE_18
	                      clear_ev ? 1'b0 : done_flag_ff;

	// ten bit interlock, frozen in break while the clear enable is low, like the flag's clear
	wire nxt_lock = !status_may_change ? lock_ff :
	                rd_rl ? 1'b0 :
	                (rd_rh && ten_bit) ? 1'b1 : lock_ff; // RULE_19

	// ------------------------------------------------------------
	// channel decode
	// ------------------------------------------------------------
	wire                ch_is_pin = (ch_ff <= acc_pkg::CH_PIN_LAST) ||
	                                (ch_ff == acc_pkg::CH_PIN8) || (ch_ff == acc_pkg::CH_PIN9);
	wire [3:0]          ch_pin    = (ch_ff <= acc_pkg::CH_PIN_LAST) ? ch_ff[3:0] :
	                                (ch_ff == acc_pkg::CH_PIN8) ? 4'h8 :
	                                (ch_ff == acc_pkg::CH_PIN9) ? 4'h9 : 4'h0;
	// unused and reserved codes still run a conversion on no source
	wire acc_pkg::acc_src_t ch_src =
		ch_is_pin                     ? acc_pkg::ACC_SRC_PIN :
		(ch_ff == acc_pkg::CH_BANDGAP) ? acc_pkg::ACC_SRC_BANDGAP :
		(ch_ff == acc_pkg::CH_REFH)    ? acc_pkg::ACC_SRC_REFH :
		(ch_ff == acc_pkg::CH_REFL)    ? acc_pkg::ACC_SRC_REFL :
		(ch_ff == acc_pkg::CH_OFF)     ? acc_pkg::ACC_SRC_OFF :
		                                 acc_pkg::ACC_SRC_UNUSED; // RULE_14 RULE_15

	// analog control word; power only while sampling or converting
	acc_pkg::acc_ana_ctl_t nxt_ana_ctl;
	assign nxt_ana_ctl.power_on    = (seq_sampling || seq_converting) && (ch_ff != acc_pkg::CH_OFF); // RULE_13
	assign nxt_ana_ctl.pad_isolate = (ch_ff == acc_pkg::CH_OFF);                                     // RULE_12
	assign nxt_ana_ctl.sample      = seq_sampling;
	assign nxt_ana_ctl.convert     = seq_converting;
	assign nxt_ana_ctl.src         = ch_src;
	assign nxt_ana_ctl.pin         = ch_pin;

	// ------------------------------------------------------------
	// read data mux
	// ------------------------------------------------------------
	wire [31:0] rd_sc = {24'h000000, done_flag_ff, irq_en_ff, cont_ff, ch_ff};
	wire [31:0] rd_rh_val = ten_bit ? {30'h00000000, result_ff[9:8]} : 32'h00000000;
	wire [31:0] rd_rl_val = ten_bit ? {24'h000000, result_ff[7:0]} : {24'h000000, result_ff[9:2]};
	wire [31:0] rd_ck = {26'h0000000, div_ff, mode_ff, long_sample_ff, async_en_ff};
	wire [31:0] rd_bc = {31'h00000000, bce_ff};
	wire [31:0] rd_mux = sel_sc ? rd_sc :
	                     sel_rh ? rd_rh_val :
	                     sel_rl ? rd_rl_val :
	                     sel_ck ? rd_ck :
	                     sel_bc ? rd_bc : 32'h00000000;

	// ------------------------------------------------------------
	// sub blocks
	// ------------------------------------------------------------
	acc_clk_div u_div
	(
		.core_clk     (core_clk),
		.resetn       (resetn),
		.clear        (conv_start),
		.div_sel      (div_ff),
		.half_tick_ff (half_tick)
	);

	acc_sar_seq u_seq
	(
		.core_clk      (core_clk),
		.resetn        (resetn),
		.start         (conv_start),
		.abort         (conv_abort),
		.half_tick     (half_tick),
		.long_sample   (long_sample_ff),
		.ana_done      (ana_done),
		.sampling_ff   (seq_sampling),
		.converting_ff (seq_converting),
		.done_ff       (seq_done)
	);

	// ------------------------------------------------------------
	// apb slave: one access cycle, answer prepared in setup
	// ------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			pready_ff  <= 1'b0;
			prdata_ff  <= 32'h00000000;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			pready_ff  <= setup;
			prdata_ff  <= (setup && !pwrite) ? rd_mux : 32'h00000000;
			pslverr_ff <= setup && !mapped;
		end
	end

	// software control fields; unmapped writes change nothing
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			irq_en_ff      <= 1'b0;
			cont_ff        <= 1'b0;
			ch_ff          <= acc_pkg::CH_RESET;
			async_en_ff    <= 1'b0;
			long_sample_ff <= 1'b0;
			mode_ff        <= acc_pkg::MODE_RESET;
			div_ff         <= acc_pkg::DIV_RESET;
			bce_ff         <= 1'b0;
		end
		else
		begin
			if (wr_sc)
			begin
				irq_en_ff <= pwdata[acc_pkg::SC_IRQ_EN_BIT];
				cont_ff   <= wr_cont;
				ch_ff     <= wr_ch;
			end
			if (wr_ck)
			begin
				async_en_ff    <= pwdata[acc_pkg::CK_ASYNC_BIT];
				long_sample_ff <= pwdata[acc_pkg::CK_LSAMP_BIT];
				mode_ff        <= pwdata[acc_pkg::CK_MODE_LSB +: 2];
				div_ff         <= pwdata[acc_pkg::CK_DIV_LSB +: 2];
			end
			if (wr_bc)
				bce_ff <= pwdata[acc_pkg::BC_BCE_BIT];
		end
	end

	// conversion status
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			done_flag_ff <= 1'b0;
			lock_ff      <= 1'b0;
			cont_run_ff  <= 1'b0; // RULE_07
			stop_q_ff    <= 1'b0;
			irq_ff       <= 1'b0;
		end
		else
		begin
			done_flag_ff <= nxt_done_flag;
			lock_ff      <= nxt_lock;
			cont_run_ff  <= nxt_cont_run;
			stop_q_ff    <= stop_mode;
			irq_ff       <= nxt_done_flag && irq_en_ff; // RULE_05
		end
	end

	// ------------------------------------------------------------
	// converter data path
	// ------------------------------------------------------------
	// the converter shows its result only in the done cycle, so it is
	// caught there and moved to the result register a cycle later
	always_ff @(posedge core_clk)
	begin
		if (!resetn)
		begin
			conv_data_ff <= 10'h000;
			result_ff    <= 10'h000;
			ana_ctl_ff   <= '{power_on: 1'b0, pad_isolate: 1'b1, sample: 1'b0, convert: 1'b0,
			                  src: acc_pkg::ACC_SRC_OFF, pin: 4'h0};
		end
		else
		begin
			if (ana_done && seq_converting)
				conv_data_ff <= ana_result;
			if (result_take)
				result_ff <= conv_data_ff; // RULE_06 RULE_21
			ana_ctl_ff   <= nxt_ana_ctl;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign prdata   = prdata_ff;
	assign pready   = pready_ff;
	assign pslverr  = pslverr_ff;
	assign conv_irq = irq_ff;
	assign ana_ctl  = ana_ctl_ff;

endmodule : acc_conv_ctrl
`default_nettype wire

// ==== testbench/acc_conv_ctrl_asserts.sv ====
// concurrent checks on the ports of the conversion control block
`default_nettype none
module acc_conv_ctrl_asserts
(
	input wire logic                  core_clk,
	input wire logic                  resetn,
	input wire logic [7:0]            paddr,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic                  break_state,
	input wire logic                  stop_mode,
	input wire logic [9:0]            ana_result,
	input wire logic                  ana_done,
	input wire acc_pkg::acc_ana_ctl_t ana_ctl,
	input wire logic                  conv_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	// ----------------------------------------
	// decoded bus events
	// ----------------------------------------
	// status write is taken at the access edge only
	wire sc_wr = psel && penable && pready && pwrite && paddr == acc_pkg::OFS_STATUS_CONTROL;
	wire setup = psel && !penable;
	wire bad   = paddr > acc_pkg::OFS_BREAK_CONTROL || paddr[1:0] != 2'h0;

	// ----------------------------------------
	// properties
	// ----------------------------------------
	// a done in flight may still win over the write's clear, so those cycles are left out
	a_write_starts: assert property (sc_wr && !stop_mode && pwdata[4:0] != acc_pkg::CH_OFF
		|-> ##2 ana_ctl.sample) else $error("status write did not start sampling");
	a_write_clears: assert property (sc_wr && !break_state && !ana_done && !$past(ana_done)
		&& !$past(ana_done, 2) |=> !conv_irq) else $error("status write left the interrupt up");
	a_off_isolates: assert property (sc_wr && pwdata[4:0] == acc_pkg::CH_OFF
		|-> ##2 !ana_ctl.power_on && ana_ctl.pad_isolate) else $error("off code kept converter powered");
	a_irq_cause: assert property ($rose(conv_irq) |-> $past(ana_done) || $past(ana_done, 2)
		|| $past(ana_done, 3)) else $error("interrupt rose without a conversion end");
	a_sample_first: assert property ($rose(ana_ctl.convert) |-> $past(ana_ctl.sample))
		else $error("convert phase without sampling phase");
	a_conv_powered: assert property (ana_ctl.convert |-> ana_ctl.power_on && !ana_ctl.pad_isolate)
		else $error("converting while powered off");
	a_pin_range: assert property (ana_ctl.power_on && ana_ctl.src == acc_pkg::ACC_SRC_PIN
		|-> ana_ctl.pin <= 4'h9) else $error("input pin out of range");
	a_bus_ready: assert property (setup |=> pready) else $error("no ready in access cycle");
	a_ready_once: assert property (pready |=> !pready) else $error("ready held two cycles");
	a_unmapped_err: assert property (setup && bad |=> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");

	c_cont_write: cover property (sc_wr && pwdata[5]);
	c_irq: cover property ($rose(conv_irq));
	c_break_done: cover property (break_state && ana_done);
endmodule : acc_conv_ctrl_asserts

bind acc_conv_ctrl acc_conv_ctrl_asserts acc_conv_ctrl_asserts_inst
(
	.core_clk(core_clk), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.break_state(break_state), .stop_mode(stop_mode), .ana_result(ana_result),
	.ana_done(ana_done), .ana_ctl(ana_ctl), .conv_irq(conv_irq)
);
`default_nettype wire

// ==== testbench/acc_ana_model.sv ====
// behavioural model of the analog converter and its input multiplexer
`default_nettype none
module acc_ana_model
(
	input  wire logic                  core_clk,
	input  wire logic                  resetn,
	input  wire acc_pkg::acc_ana_ctl_t ana_ctl,
	input  wire logic [3:0]            lat,
	output var  logic                  ana_done,
	output var  logic [9:0]            ana_result
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_ff;
	logic       sent_ff;

	// one done pulse per convert phase after lat cycles; result encodes source and pin,
	// and outside the done cycle the bus toggles so a late sample never sees a stale value
	always_ff @(posedge core_clk)
	begin
		ana_done <= 1'b0;
		ana_result <= ~ana_result;
		if (!resetn || !ana_ctl.convert)
		begin
			cnt_ff <= lat;
			sent_ff <= 1'b0;
			if (!resetn)
				ana_result <= 10'h000;
		end
		else if (cnt_ff != 4'h0)
			cnt_ff <= cnt_ff - 4'h1;
		else if (!sent_ff)
		begin
			ana_done <= 1'b1;
			sent_ff <= 1'b1;
			ana_result <= {ana_ctl.src, ana_ctl.pin, 3'h5};
		end
	end
endmodule : acc_ana_model
`default_nettype wire

// ==== testbench/acc_conv_ctrl_tb_top.sv ====
// self-checking bench of the conversion control block
`default_nettype none
module acc_conv_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] SC = acc_pkg::OFS_STATUS_CONTROL;
	localparam logic [7:0] RH = acc_pkg::OFS_RESULT_HIGH;
	localparam logic [7:0] RL = acc_pkg::OFS_RESULT_LOW;
	localparam logic [7:0] CK = acc_pkg::OFS_CLOCK;
	localparam logic [7:0] BC = acc_pkg::OFS_BREAK_CONTROL;
	logic                  core_clk, resetn, psel, penable, pwrite, pready, pslverr, err;
	logic                  break_state, stop_mode, ana_done, conv_irq;
	logic [7:0]            paddr;
	logic [31:0]           pwdata, prdata, r;
	logic [9:0]            ana_result, res;
	logic [3:0]            lat;
	acc_pkg::acc_ana_ctl_t ana_ctl;
	int                    error_cnt = 0;
	int                    total_checks = 0;
	// channel codes with expected source (7: undefined) and pin
	logic [4:0]            codes [9] = '{5'h00, 5'h07, 5'h18, 5'h19, 5'h1A, 5'h1D, 5'h1E, 5'h08, 5'h1B};
	logic [2:0]            srcs [9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h7};
	logic [3:0]            pins [4] = '{4'h0, 4'h7, 4'h8, 4'h9};

	acc_conv_ctrl acc_conv_ctrl_inst (.core_clk(core_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .break_state(break_state), .stop_mode(stop_mode), .ana_result(ana_result),
		.ana_done(ana_done), .ana_ctl(ana_ctl), .conv_irq(conv_irq));
	acc_ana_model acc_ana_model_inst (.core_clk(core_clk), .resetn(resetn), .ana_ctl(ana_ctl), .lat(lat),
		.ana_done(ana_done), .ana_result(ana_result));

	// ----------------------------------------
	// bus and check tasks
	// ----------------------------------------
	// request held until the rising edge that sees pready; data taken at that same edge
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1 && n < 50)
		begin
			@(posedge core_clk);
			n++;
		end
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
		check(n < 50, 1'b1);
	endtask : apb
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error at %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		apb(a, 1'b0, 32'h0);
	endtask : rd
	// polls the status word, bounded, until the done flag shows
	task automatic wait_flag();
		int n;
		n = 0;
		rd(SC);
		while (r[7] !== 1'b1 && n < 200)
		begin
			rd(SC);
			n++;
		end
		check(r[7], 1'b1);
	endtask : wait_flag
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	// ----------------------------------------
	// clock, watchdog
	// ----------------------------------------
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	initial
	begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		finish_test();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		{resetn, psel, penable, pwrite, break_state, stop_mode} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		lat = 4'h3;
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		rd(SC); check(r, 32'h1F);
		check(ana_ctl.pad_isolate, 1'b1);
		rd(CK); check(r, 32'h0);
		rd(8'h14); check({err, r[30:0]}, 32'h80000000);
		$display("test reset done");
		wr(SC, 32'h00); wait_flag();
		check(conv_irq, 1'b0);
		rd(RL); check(r, 32'h01);
		repeat (100) @(posedge core_clk);
		rd(SC); check(r, 32'h00);
		$display("test single done");
		wr(CK, 32'h04);
		for (int i = 0; i < 9; i++)
		begin
			wr(SC, {24'h0, 3'h2, codes[i]}); wait_flag();
			check(conv_irq, 1'b1);
			rd(RH); res[9:8] = r[1:0];
			rd(RL); res[7:0] = r[7:0];
			if (srcs[i] != 3'h7) check(res[9:7], srcs[i]);
			if (i < 4) check(res[6:3], pins[i]);
			rd(SC); check({conv_irq, r[7:0]}, {1'b0, 3'h2, codes[i]});
			check(ana_ctl.power_on, 1'b0);
		end
		wr(SC, 32'h19); wait_flag(); rd(RH);
		wr(SC, 32'h00); wait_flag(); rd(RL); check(r, 32'h4D);
		$display("test decode done");
		wr(SC, 32'h21); wait_flag(); rd(RL); check(r, 32'h0D);
		wait_flag(); rd(RL);
		wr(SC, 32'h3F);
		repeat (100) @(posedge core_clk);
		check({ana_ctl.power_on, ana_ctl.pad_isolate}, 2'h1);
		rd(SC); check(r, 32'h3F);
		lat <= 4'hC;
		wr(SC, 32'h22); wait_flag(); rd(RL); check(r, 32'h15);
		stop_mode <= 1'b1;
		repeat (100) @(posedge core_clk);
		stop_mode <= 1'b0;
		repeat (100) @(posedge core_clk);
		rd(SC); check(r, 32'h22);
		rd(RL); check(r, 32'h15);
		wr(SC, 32'h23); wait_flag(); rd(RL); check(r, 32'h1D);
		wr(CK, 32'h04);
		repeat (60) @(posedge core_clk);
		rd(RL);
		repeat (100) @(posedge core_clk);
		rd(SC); check(r, 32'h23);
		$display("test continuous done");
		wr(SC, 32'h01);
		repeat (12) @(posedge core_clk);
		wr(SC, 32'h1F);
		repeat (100) @(posedge core_clk);
		rd(SC); check(r, 32'h1F);
		rd(RL); check(r, 32'h1D);
		wr(SC, 32'h01);
		repeat (12) @(posedge core_clk);
		wr(SC, 32'h02); wait_flag(); rd(RL); check(r, 32'h15);
		repeat (100) @(posedge core_clk);
		rd(SC); check(r, 32'h02);
		$display("test abort done");
		lat <= 4'h3;
		wr(SC, 32'h40); wait_flag();
		break_state <= 1'b1;
		rd(RL); rd(SC); check({conv_irq, r[7]}, 2'h3);
		break_state <= 1'b0;
		rd(RL); rd(SC); check(r[7], 1'b0);
		wr(BC, 32'h1); rd(BC); check(r, 32'h1);
		wr(SC, 32'h40); wait_flag();
		break_state <= 1'b1;
		rd(RL);
		break_state <= 1'b0;
		rd(SC); check(r[7], 1'b0);
		$display("test break done");
		finish_test();
	end
endmodule : acc_conv_ctrl_tb_top
`default_nettype wire
